// File: core/pfcc_pkg.sv
// Constants and types for the host-side parallel flash command controller.
// Assumes a 25 MHz ref_clk and an asynchronous NOR flash on the far side of the pins.
// Overview of operation
// - Top data pin is address LSB in byte mode
// - Erase suspend pauses erase; resume continues it
// - Host pulses write strobe for each command cycle
// - Host supplies command sequence only, no timing
package pfcc_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_HZ = 25_000_000;
  // Bus cycle phase lengths, ns
  localparam int T_SETUP_NS = 40;
  localparam int T_PULSE_NS = 50;
  localparam int T_HOLD_NS = 30;
  localparam int T_ACCESS_NS = 70;
  localparam int T_RESET_NS = 500;
  localparam int NS_PER_S = 1_000_000_000;
  // Extra read cycles while data pins cross the input synchroniser
  localparam int SYNC_CYC = 3;
  // Least times round up to whole cycles, never below one
  localparam int SETUP_CYC = (T_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ACCESS_CYC = (T_ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + SYNC_CYC;
  localparam int RESET_CYC = (T_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W = 8;
  // Polling bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  typedef enum logic [1:0] {PFCC_OP_WRITE, PFCC_OP_READ, PFCC_OP_RESET} pfcc_op_t;
  typedef enum logic [2:0] {
    PFCC_IDLE, PFCC_SETUP, PFCC_STROBE, PFCC_HOLD, PFCC_DONE, PFCC_RST
  } pfcc_state_t;
endpackage : pfcc_pkg

// File: core/pfcc_sync.sv
// Three-stage input synchroniser for the flash side pins.
// Assumes inputs change asynchronously to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pfcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          out_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // A change counts once stages two and three agree
          if (s2_r[i] == s3_r[i]) begin
            out_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
  assign dout = out_r;
endmodule : pfcc_sync
`default_nettype wire

// File: core/pfcc_host.sv
// Host-side bus controller that drives an asynchronous parallel NOR flash.
// Assumes one user command at a time; the user builds unlock and command sequences.
`timescale 1ns/1ps
`default_nettype none
module pfcc_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // User request
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [pfcc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [pfcc_pkg::DATA_W-1:0] req_wdata,
  input wire logic word_mode,
  input wire logic protect_en,
  input wire logic accel_en,
  // User answer
  output logic req_ready,
  output logic rsp_valid,
  output logic [pfcc_pkg::DATA_W-1:0] rsp_rdata,
  output logic dev_busy,
  output logic op_done,
  // Flash pins
  output logic chip_en_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic reset_n,
  output logic byte_n,
  output logic protect_accelerate_n,
  output logic accel_hv,
  output logic [pfcc_pkg::ADDR_W-1:0] addr,
  input wire logic [pfcc_pkg::DATA_W-1:0] data_i,
  output logic [pfcc_pkg::DATA_W-1:0] data_o,
  output logic [pfcc_pkg::DATA_W-1:0] data_oe,
  input wire logic ready_busy_n
);
  pfcc_pkg::pfcc_state_t st_r, st_nxt;
  logic [pfcc_pkg::CNT_W-1:0] cnt_r;
  pfcc_pkg::pfcc_op_t op_r;
  logic [pfcc_pkg::ADDR_W-1:0] addr_r;
  logic [pfcc_pkg::DATA_W-1:0] wdata_r;
  logic word_r;
  logic ce_n_r, oe_n_r, we_n_r, rst_n_r, drive_r;
  logic [pfcc_pkg::DATA_W-1:0] rdata_r;
  logic rsp_r, busy_r, done_r, rdy_r;
  logic [pfcc_pkg::DATA_W-1:0] data_s;
  logic busy_s;
  logic [pfcc_pkg::ADDR_W-1:0] addr_o_r;
  logic [pfcc_pkg::DATA_W-1:0] data_o_r;
  logic [pfcc_pkg::DATA_W-1:0] data_oe_r;
  logic busy_prev_r;
  logic byte_n_r, pa_n_r, hv_r;

  pfcc_sync #(.W(pfcc_pkg::DATA_W + 1)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    // Busy goes in asserted so that the synchroniser's reset value reads as idle
    .din({~ready_busy_n, data_i}),
    .dout({busy_s, data_s})
  );

  wire cnt_zero = (cnt_r == '0);
  wire accept = rdy_r && (st_r == pfcc_pkg::PFCC_IDLE) && req_valid;
  wire is_write = (op_r == pfcc_pkg::PFCC_OP_WRITE);
  wire is_read = (op_r == pfcc_pkg::PFCC_OP_READ);
  // Request values as they stand after this edge, so pins move with the state
  wire write_nxt = accept ? (req_op == 2'(pfcc_pkg::PFCC_OP_WRITE)) : is_write;
  wire word_nxt = accept ? word_mode : word_r;
  wire [pfcc_pkg::ADDR_W-1:0] addr_nxt = accept ? req_addr : addr_r;
  wire [pfcc_pkg::DATA_W-1:0] wdata_nxt = accept ? req_wdata : wdata_r;
  wire bus_nxt = (st_nxt == pfcc_pkg::PFCC_SETUP) || (st_nxt == pfcc_pkg::PFCC_STROBE) ||
    (st_nxt == pfcc_pkg::PFCC_HOLD);
  wire drive_nxt = write_nxt && bus_nxt;
  wire [pfcc_pkg::CNT_W-1:0] setup_c = pfcc_pkg::CNT_W'(pfcc_pkg::SETUP_CYC - 1);
  wire [pfcc_pkg::CNT_W-1:0] pulse_c = pfcc_pkg::CNT_W'(pfcc_pkg::PULSE_CYC - 1);
  wire [pfcc_pkg::CNT_W-1:0] access_c = pfcc_pkg::CNT_W'(pfcc_pkg::ACCESS_CYC - 1);
  wire [pfcc_pkg::CNT_W-1:0] hold_c = pfcc_pkg::CNT_W'(pfcc_pkg::HOLD_CYC - 1);
  wire [pfcc_pkg::CNT_W-1:0] rst_c = pfcc_pkg::CNT_W'(pfcc_pkg::RESET_CYC - 1);
  // Byte mode: the lowest address bit rides the top data pin
  wire [pfcc_pkg::DATA_W-1:0] wdata_pin = word_nxt ? wdata_nxt :
    {addr_nxt[0], wdata_nxt[pfcc_pkg::DATA_W-2:0]};
  wire [pfcc_pkg::ADDR_W-1:0] addr_pin = word_nxt ? addr_nxt :
    {1'b0, addr_nxt[pfcc_pkg::ADDR_W-1:1]};
  wire [pfcc_pkg::DATA_W-1:0] oe_drive = drive_nxt ? {pfcc_pkg::DATA_W{1'b1}} :
    (word_nxt ? {pfcc_pkg::DATA_W{1'b0}} : {1'b1, {(pfcc_pkg::DATA_W-1){1'b0}}});

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pfcc_pkg::PFCC_IDLE: begin
        if (accept) begin
          st_nxt = (req_op == 2'(pfcc_pkg::PFCC_OP_RESET)) ? pfcc_pkg::PFCC_RST :
            pfcc_pkg::PFCC_SETUP;
        end
      end
      pfcc_pkg::PFCC_SETUP: begin
        if (cnt_zero) begin
          st_nxt = pfcc_pkg::PFCC_STROBE;
        end
      end
      pfcc_pkg::PFCC_STROBE: begin
        if (cnt_zero) begin
          st_nxt = pfcc_pkg::PFCC_HOLD;
        end
      end
      pfcc_pkg::PFCC_HOLD: begin
        if (cnt_zero) begin
          st_nxt = pfcc_pkg::PFCC_DONE;
        end
      end
      pfcc_pkg::PFCC_RST: begin
        if (cnt_zero) begin
          st_nxt = pfcc_pkg::PFCC_DONE;
        end
      end
      default: begin
        st_nxt = pfcc_pkg::PFCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= pfcc_pkg::PFCC_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        case (st_nxt)
          pfcc_pkg::PFCC_SETUP: cnt_r <= setup_c;
          pfcc_pkg::PFCC_STROBE: cnt_r <= is_read || (accept && req_op ==
            2'(pfcc_pkg::PFCC_OP_READ)) ? access_c : pulse_c;
          pfcc_pkg::PFCC_HOLD: cnt_r <= hold_c;
          pfcc_pkg::PFCC_RST: cnt_r <= rst_c;
          default: cnt_r <= '0;
        endcase
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_r <= pfcc_pkg::PFCC_OP_READ;
      addr_r <= '0;
      wdata_r <= '0;
      word_r <= 1'b1;
    end else if (accept) begin
      op_r <= pfcc_pkg::pfcc_op_t'(req_op);
      addr_r <= req_addr;
      wdata_r <= req_wdata;
      word_r <= word_mode;
    end
  end

  // Pin drive: writes hold OE high while CE and WE are low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      drive_r <= 1'b0;
    end else begin
      ce_n_r <= !bus_nxt;
      // Suspend and resume travel as plain write cycles
      we_n_r <= !(st_nxt == pfcc_pkg::PFCC_STROBE && is_write);
      oe_n_r <= !(st_nxt == pfcc_pkg::PFCC_STROBE && is_read);
      drive_r <= drive_nxt;
    end
  end

  // Address and data pins leave flops, set up with chip enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr_o_r <= '0;
      data_o_r <= '0;
      data_oe_r <= '0;
    end else begin
      addr_o_r <= addr_pin;
      data_o_r <= wdata_pin;
      data_oe_r <= oe_drive;
    end
  end

  // Reset pin pulse returns the flash to read mode; no internal timing is driven
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_n_r <= 1'b1;
      byte_n_r <= 1'b1;
      pa_n_r <= 1'b1;
      hv_r <= 1'b0;
    end else begin
      rst_n_r <= !(st_nxt == pfcc_pkg::PFCC_RST);
      byte_n_r <= word_nxt;
      pa_n_r <= !protect_en;
      hv_r <= accel_en && !protect_en;
    end
  end

  // Read capture after the access time; busy and completion track the ready/busy pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
      rsp_r <= 1'b0;
      busy_r <= 1'b0;
      busy_prev_r <= 1'b0;
      done_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      rsp_r <= (st_r == pfcc_pkg::PFCC_STROBE) && cnt_zero && is_read;
      if ((st_r == pfcc_pkg::PFCC_STROBE) && cnt_zero && is_read) begin
        rdata_r <= word_r ? data_s : {8'h00, data_s[7:0]};
      end
      busy_r <= busy_s;
      busy_prev_r <= busy_r;
      done_r <= busy_prev_r && !busy_r;
      rdy_r <= (st_nxt == pfcc_pkg::PFCC_IDLE);
    end
  end

  assign req_ready = rdy_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign dev_busy = busy_r;
  assign op_done = done_r;
  assign chip_en_n = ce_n_r;
  assign out_en_n = oe_n_r;
  assign write_en_n = we_n_r;
  assign reset_n = rst_n_r;
  assign byte_n = byte_n_r;
  assign protect_accelerate_n = pa_n_r;
  assign accel_hv = hv_r;
  assign addr = addr_o_r;
  assign data_o = data_o_r;
  assign data_oe = data_oe_r;

  AST_WE_NOT_WITH_OE: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(!write_en_n && !out_en_n)) else $error("write and output enable both low");
  AST_WE_NEEDS_CE: assert property (@(posedge ref_clk) disable iff (!rstn)
    !write_en_n |-> !chip_en_n && drive_r) else $error("strobe without chip enable");
  AST_RESET_LEN: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(reset_n) |-> !reset_n [*2]) else $error("reset pulse too short");
  AST_RSP_AFTER_OE: assert property (@(posedge ref_clk) disable iff (!rstn)
    rsp_valid |-> $past(!out_en_n)) else $error("read answer without output enable");
  AST_DONE_EDGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_done |-> !dev_busy && $past(dev_busy, 2)) else $error("done without busy end");
  AST_PA_PIN: assert property (@(posedge ref_clk) disable iff (!rstn)
    protect_en |=> !protect_accelerate_n && !accel_hv) else $error("protect pin wrong");
  AST_BYTE_PIN: assert property (@(posedge ref_clk) disable iff (!rstn)
    !chip_en_n |-> byte_n == word_r) else $error("width pin mismatch");
  AST_TOP_PIN: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!chip_en_n && !word_r) |-> data_oe[15] && data_o[15] == addr_r[0])
    else $error("byte mode address lsb missing");
  COV_WRITE: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(write_en_n));
  COV_READ: cover property (@(posedge ref_clk) disable iff (!rstn) rsp_valid);
  COV_RESET: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(reset_n));
  COV_DONE: cover property (@(posedge ref_clk) disable iff (!rstn) op_done);
endmodule : pfcc_host
`default_nettype wire

// File: verification/pfcc_flash_model.sv
// Behavioural parallel NOR flash on the far side of the host controller pins.
// Assumes one host; unlock cycles are not modelled, so 0xA0 alone arms a program.
`timescale 1ns/1ps
`default_nettype none
module pfcc_flash_model #(
  parameter int BUSY_NS = 3000
) (
  // Control pins
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic reset_n,
  input wire logic byte_n,
  input wire logic protect_accelerate_n,
  input wire logic accel_hv,
  // Address and data pins
  input wire logic [20:0] addr,
  input wire logic [15:0] data_o,
  input wire logic [15:0] data_oe,
  output logic [15:0] data_i,
  output logic ready_busy_n
);
  // Sparse byte array spans the whole byte address space; unwritten bytes read as 0xFF
  logic [7:0] mem [int];
  logic busy = 1'b0;
  logic armed = 1'b0;
  logic tgl = 1'b0;
  logic [15:0] q = 16'h0000;
  logic [15:0] pdata = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  int pa = 0;
  wire [21:0] ba = byte_n ? {addr, 1'b0} : {addr, data_o[15]};
  wire [15:0] dmask = (!chip_en_n && !out_en_n) ? (byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  wire [15:0] en = data_oe | dmask;
  wire [15:0] drv = (data_oe & data_o) | (dmask & q);
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  // Released bits show the inverse of their last level, so stale data cannot pass
  always @(drv or en) last_q = (drv & en) | (last_q & ~en);
  assign data_i = (drv & en) | (~last_q & ~en);
  assign ready_busy_n = ~busy;
  always @(negedge out_en_n) if (!chip_en_n) begin
    tgl = ~tgl;
    q = byte_n ? {rd(int'(ba) + 1), rd(int'(ba))} : {8'h00, rd(int'(ba))};
    if (busy) q = {8'h00, ~pdata[7], tgl, 6'h00};
  end
  always @(posedge write_en_n) if (!chip_en_n && out_en_n && reset_n && !busy) begin
    if (armed && protect_accelerate_n) begin
      pa = int'(ba);
      pdata = data_o;
      busy = 1'b1;
    end
    armed = !armed && data_o[7:0] == 8'hA0;
  end
  always begin : seq_run
    wait (busy);
    #(accel_hv ? BUSY_NS / 4 : BUSY_NS);
    mem[pa] = rd(pa) & pdata[7:0];
    if (byte_n) mem[pa + 1] = rd(pa + 1) & pdata[15:8];
    busy = 1'b0;
  end
  always @(negedge reset_n) begin
    busy = 1'b0;
    armed = 1'b0;
    disable seq_run;
  end
endmodule : pfcc_flash_model
`default_nettype wire

// File: verification/test_parallel_flash_command_control.sv
// Self-checking bench for the host-side flash command controller.
// Assumes the behavioural flash model answers on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_parallel_flash_command_control;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [pfcc_pkg::ADDR_W-1:0] req_addr = 21'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic word_mode = 1'b1;
  logic protect_en = 1'b0;
  logic accel_en = 1'b0;
  logic req_ready, rsp_valid, dev_busy, op_done, chip_en_n, out_en_n, write_en_n;
  logic reset_n, byte_n, protect_accelerate_n, accel_hv, ready_busy_n, oe_clash;
  logic [pfcc_pkg::ADDR_W-1:0] addr;
  logic [15:0] rsp_rdata, data_i, data_o, data_oe, rd_q;
  int mismatches = 0;
  int samples_checked = 0;
  int done_cnt = 0;
  int we_cnt, rst_cnt;
  pfcc_host pfcc_host_inst (.ref_clk, .rstn, .req_valid, .req_op, .req_addr, .req_wdata,
    .word_mode, .protect_en, .accel_en, .req_ready, .rsp_valid, .rsp_rdata, .dev_busy,
    .op_done, .chip_en_n, .out_en_n, .write_en_n, .reset_n, .byte_n, .protect_accelerate_n,
    .accel_hv, .addr, .data_i, .data_o, .data_oe, .ready_busy_n);
  pfcc_flash_model #(.BUSY_NS(3000)) pfcc_flash_model_inst (.chip_en_n, .out_en_n,
    .write_en_n, .reset_n, .byte_n, .protect_accelerate_n, .accel_hv, .addr, .data_o,
    .data_oe, .data_i, .ready_busy_n);
  initial forever #20 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (op_done === 1'b1) done_cnt++;
  task automatic xfer(input logic [1:0] op, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    we_cnt = 0;
    rst_cnt = 0;
    oe_clash = 1'b0;
    @(posedge ref_clk);
    #1 {req_op, req_addr, req_wdata, req_valid} = {op, a, d, 1'b1};
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    // Count strobe cycles at mid-cycle, where every registered pin has settled
    do begin
      @(negedge ref_clk);
      n++;
      we_cnt += int'(write_en_n === 1'b0);
      rst_cnt += int'(reset_n === 1'b0);
      if (write_en_n === 1'b0 && out_en_n !== 1'b1) oe_clash = 1'b1;
      if (rsp_valid === 1'b1) rd_q = rsp_rdata;
    end while (req_ready !== 1'b1 && n < 120);
  endtask : xfer
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (dev_busy !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_busy
  task automatic t_write_walk;
    xfer(2'h0, 21'h000555, 16'h00AA);
    `CHECK_EQ("strobe_cycles", pfcc_pkg::PULSE_CYC, we_cnt)
    `CHECK_EQ("oe_during_strobe", 1'b0, oe_clash)
  endtask : t_write_walk
  task automatic t_program_word;
    int d0;
    logic tg;
    d0 = done_cnt;
    xfer(2'h0, 21'h000000, 16'h00A0);
    xfer(2'h0, 21'h000010, 16'h1234);
    wait_busy(1'b1, 20);
    `CHECK_EQ("busy_rise", 1'b1, dev_busy)
    xfer(2'h1, 21'h000010, 16'h0000);
    `CHECK_EQ("poll_bit", 1'b1, rd_q[7])
    tg = rd_q[6];
    xfer(2'h1, 21'h000010, 16'h0000);
    `CHECK_EQ("toggle_bit", ~tg, rd_q[6])
    wait_busy(1'b0, 200);
    `CHECK_EQ("busy_fall", 1'b0, dev_busy)
    xfer(2'h1, 21'h000010, 16'h0000);
    `CHECK_EQ("word_data", 16'h1234, rd_q)
    `CHECK_EQ("done_pulses", d0 + 1, done_cnt)
  endtask : t_program_word
  task automatic t_byte_mode;
    @(posedge ref_clk) #1 word_mode = 1'b0;
    xfer(2'h0, 21'h000000, 16'h00A0);
    `CHECK_EQ("byte_pin", 1'b0, byte_n)
    xfer(2'h0, 21'h000041, 16'h005A);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 200);
    xfer(2'h1, 21'h000041, 16'h0000);
    `CHECK_EQ("odd_byte", 8'h5A, rd_q[7:0])
    xfer(2'h1, 21'h000040, 16'h0000);
    `CHECK_EQ("even_byte", 8'hFF, rd_q[7:0])
    @(posedge ref_clk) #1 word_mode = 1'b1;
  endtask : t_byte_mode
  task automatic t_reset;
    xfer(2'h0, 21'h000000, 16'h00A0);
    xfer(2'h2, 21'h000000, 16'h0000);
    `CHECK_EQ("reset_cycles", pfcc_pkg::RESET_CYC, rst_cnt)
    xfer(2'h0, 21'h000030, 16'h0000);
    wait_busy(1'b1, 20);
    `CHECK_EQ("no_program", 1'b0, dev_busy)
  endtask : t_reset
  task automatic t_protect;
    @(posedge ref_clk) #1 {protect_en, accel_en} = 2'h3;
    xfer(2'h0, 21'h000000, 16'h00A0);
    `CHECK_EQ("protect_pin", 1'b0, protect_accelerate_n)
    `CHECK_EQ("accel_blocked", 1'b0, accel_hv)
    xfer(2'h0, 21'h000050, 16'h0000);
    wait_busy(1'b1, 20);
    `CHECK_EQ("protected_busy", 1'b0, dev_busy)
    @(posedge ref_clk) #1 protect_en = 1'b0;
    xfer(2'h0, 21'h000000, 16'h00A0);
    `CHECK_EQ("accel_pin", 1'b1, accel_hv)
    xfer(2'h0, 21'h000050, 16'h0000);
    wait_busy(1'b1, 20);
    // Accelerated programming ends well inside the normal busy time
    wait_busy(1'b0, 30);
    `CHECK_EQ("accel_fast", 1'b0, dev_busy)
    xfer(2'h1, 21'h000050, 16'h0000);
    `CHECK_EQ("accel_program", 16'h0000, rd_q)
    @(posedge ref_clk) #1 accel_en = 1'b0;
  endtask : t_protect
  task automatic complete_run;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_write_walk();
    t_program_word();
    t_byte_mode();
    t_reset();
    t_protect();
    complete_run();
  end
  // Scenarios need a few hundred cycles; this limit of 10,000 cycles leaves ample margin
  initial begin
    #400_000;
    mismatches++;
    complete_run();
  end
endmodule : test_parallel_flash_command_control
`default_nettype wire
